// ===== rtl/dmtc_pkg.sv
// package: register map, field positions, reset values and timing counts for the timer block
package dmtc_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [3:0] ADDR_MODE    = 4'h0;  // timer_mode_register
  localparam logic [3:0] ADDR_CTRL    = 4'h4;  // timer_control_register
  localparam logic [3:0] ADDR_LOW0    = 4'h8;
  localparam logic [3:0] ADDR_HIGH0   = 4'hC;
  // second bank selected by address bit 4
  localparam logic [4:0] ADDR_LOW1    = 5'h10;
  localparam logic [4:0] ADDR_HIGH1   = 5'h14;
  localparam logic [4:0] ADDR_STATUS  = 5'h18;
  localparam logic [4:0] ADDR_MASK    = 5'h1C;
  localparam int          ADDR_W      = 5;
  // control register fields
  localparam int          CTRL_RUN0   = 4;
  localparam int          CTRL_OVF0   = 5;
  localparam int          CTRL_RUN1   = 6;
  localparam int          CTRL_OVF1   = 7;
  // mode register fields (per timer nibble)
  localparam int          MODE_LOW    = 0;
  localparam int          MODE_HIGH   = 1;
  localparam int          MODE_CNT    = 2;
  localparam int          MODE_GATE   = 3;
  localparam int          NIB_W       = 4;
  // operating modes
  typedef enum logic [1:0] {
    DMTC_M_PRESC  = 2'b00,
    DMTC_M_WIDE   = 2'b01,
    DMTC_M_RELOAD = 2'b10,
    DMTC_M_SPLIT  = 2'b11
  } dmtc_mode_t;
  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [4:0]  RST_PRESC   = 5'h00;
  localparam logic [1:0]  RST_EVT     = 2'h0;
  // machine cycle timing
  localparam int          OSC_PER_MC  = 12;
  localparam logic [3:0]  MC_LAST     = 4'(OSC_PER_MC - 1);
  localparam logic [3:0]  MC_SAMPLE   = 4'h9;  // phase used as the count sample point
  localparam int          PRESC_DIV   = 32;
  localparam logic [4:0]  PRESC_LAST  = 5'(PRESC_DIV - 1);
endpackage

// ===== rtl/dmtc_phase_gen.sv
// machine-cycle phase counter: one tick per twelve clocks plus a sample strobe
`timescale 1ns/1ps
`default_nettype none
module dmtc_phase_gen (
  input  wire logic mclk,
  input  wire logic rstn,
  output logic      mcTick,
  output logic      sampleTick
);
  logic [3:0] phase;
  logic [3:0] next_phase;

  // wrap every twelve oscillator periods
  always_comb begin
    next_phase = (phase == dmtc_pkg::MC_LAST) ? 4'h0 : 4'(phase + 4'h1);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase <= 4'h0;
    end else begin
      phase <= next_phase;
    end
  end

  assign mcTick     = (phase == dmtc_pkg::MC_LAST);
  assign sampleTick = (phase == dmtc_pkg::MC_SAMPLE);
endmodule
`default_nettype wire

// ===== rtl/dmtc_edge_det.sv
// count-pin sampler: one sample per machine cycle, high then low gives a pulse
`timescale 1ns/1ps
`default_nettype none
module dmtc_edge_det (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic sampleTick,
  input  wire logic mcTick,
  input  wire logic pinIn,
  output logic      fallEvt
);
  logic curSample;
  logic pend;
  logic next_curSample;
  logic next_pend;

  // the edge is recognised after two samples; counted at the next cycle end
  always_comb begin
    next_curSample  = curSample;
    next_pend       = pend;
    if (sampleTick) begin
      // only the latest sample is kept; the new pin value is the second one
      next_curSample  = pinIn;
      next_pend       = curSample & ~pinIn;
    end else if (mcTick) begin
      next_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      curSample  <= 1'b0;
      pend       <= 1'b0;
    end else begin
      curSample  <= next_curSample;
      pend       <= next_pend;
    end
  end

  assign fallEvt = pend & mcTick;
endmodule
`default_nettype wire

// ===== rtl/dmtc_timer_top.sv
// two 16-bit timer/counters with four modes, wishbone registers and an interrupt
//
// Functional notes
// - timer function counts one per machine cycle of twelve clocks.
// - each timer picks internal cycles or its external count pin.
// - count pin sampled once per machine cycle; high then low counts.
// - edge recognition takes two machine cycles from the high sample.
// - mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - mode 1 cascades high and low bytes into one 16-bit counter.
// - mode 2 is 8-bit, reloaded on every overflow.
// - mode 3 splits timer 0 in two; timer 1 in mode 3 stops.
// - with timer 0 in mode 3, timer 1 runs but raises no flag.
// - timer 1 overflow pulse always leaves for the baud generator.
// - a gate pin can gate internal or external source.
// - each timer starts and stops by its software run bit, and by its gate pin when gated.
// - overflow flag set on rollover to zero or to the reload value.
// - in reload mode the high byte is copied into the low byte.
// - gated timers count only while gate pin high and run bit set.
// - hardware sets overflow flags; reading the status register acknowledges the interrupt.
// - split mode high byte uses timer 1 run bit and timer 1 flag.
`timescale 1ns/1ps
`default_nettype none
module dmtc_timer_top (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        countInputZero,
  input  wire logic        countInputOne,
  input  wire logic        gateInputZero,
  input  wire logic        gateInputOne,
  output logic             baudPulse,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  // shared strobes
  // one phase counter serves both timers so their machine cycles stay aligned
  logic mcTick;
  logic sampleTick;
  logic fallZero;
  logic fallOne;

  dmtc_phase_gen uPhase (
    .mclk       (mclk),
    .rstn       (rstn),
    .mcTick     (mcTick),
    .sampleTick (sampleTick)
  );

  dmtc_edge_det uEdgeZero (
    .mclk       (mclk),
    .rstn       (rstn),
    .sampleTick (sampleTick),
    .mcTick     (mcTick),
    .pinIn      (countInputZero),
    .fallEvt    (fallZero)
  );

  dmtc_edge_det uEdgeOne (
    .mclk       (mclk),
    .rstn       (rstn),
    .sampleTick (sampleTick),
    .mcTick     (mcTick),
    .pinIn      (countInputOne),
    .fallEvt    (fallOne)
  );

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  timerModeRegister;
  logic [7:0]  timerControlRegister;
  logic [7:0]  lowByte  [2];
  logic [7:0]  highByte [2];
  logic [4:0]  presc    [2];
  logic [1:0]  status;
  logic [1:0]  mask;
  logic        ack;
  logic        baud;
  logic [31:0] rdData;

  // next values, built in the combinational blocks below
  logic [7:0]  next_timerModeRegister;
  logic [7:0]  next_timerControlRegister;
  logic [7:0]  next_lowByte  [2];
  logic [7:0]  next_highByte [2];
  logic [4:0]  next_presc    [2];
  logic [1:0]  next_status;
  logic [1:0]  next_mask;
  logic        next_ack;
  logic        next_baud;
  logic [31:0] next_rdData;

  // decoded bus access
  // only byte lane 0 carries register data; the other lanes are ignored
  logic        req;
  logic        wrReq;
  logic        rdReq;
  assign req   = wb_cyc_i & wb_stb_i & ~ack;
  assign wrReq = req & wb_we_i & wb_sel_i[0];
  assign rdReq = req & ~wb_we_i;

  // address match shared by every write decode below
  function automatic logic hit(input logic [4:0] adr, input logic [4:0] ref_adr);
    hit = (adr == ref_adr);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // count enables per timer
  logic [1:0] runBit;
  logic [1:0] gatePin;
  logic [1:0] srcTick;
  logic [1:0] enable;
  logic [1:0] mode [2];
  logic       splitZero;

  assign runBit[0]  = timerControlRegister[dmtc_pkg::CTRL_RUN0];
  assign runBit[1]  = timerControlRegister[dmtc_pkg::CTRL_RUN1];
  assign gatePin[0] = gateInputZero;
  assign gatePin[1] = gateInputOne;
  // counter function takes the edge pulse, timer function the machine tick
  assign srcTick[0] = timerModeRegister[dmtc_pkg::MODE_CNT] ? fallZero : mcTick;
  assign srcTick[1] = timerModeRegister[dmtc_pkg::NIB_W + dmtc_pkg::MODE_CNT]
                      ? fallOne : mcTick;
  // timer 0 split borrows the timer 1 run bit for its high byte
  assign splitZero  = (mode[0] == 2'(dmtc_pkg::DMTC_M_SPLIT));

  // the gate pin only matters while its gate bit is set
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gEnable
      logic gated;
      assign mode[gi] = {timerModeRegister[gi*dmtc_pkg::NIB_W + dmtc_pkg::MODE_HIGH],
                         timerModeRegister[gi*dmtc_pkg::NIB_W + dmtc_pkg::MODE_LOW]};
      assign gated = timerModeRegister[gi*dmtc_pkg::NIB_W + dmtc_pkg::MODE_GATE];
      // run bit alone, or run bit with gate pin high
      assign enable[gi] = runBit[gi] & (~gated | gatePin[gi]) & srcTick[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // counting, flags and register writes
  always_comb begin
    logic [1:0] ovf;
    logic       ovfHighZero;
    logic [8:0] sumLow;
    logic [8:0] sumHigh;
    ovf                       = 2'b00;
    ovfHighZero               = 1'b0;
    sumLow                    = 9'h000;
    sumHigh                   = 9'h000;
    next_timerModeRegister    = timerModeRegister;
    next_timerControlRegister = timerControlRegister;
    next_lowByte              = lowByte;
    next_highByte             = highByte;
    next_presc                = presc;
    next_status               = status;
    next_mask                 = mask;
    next_baud                 = 1'b0;

    // both timers can step in the same clock; sumLow and sumHigh are scratch values reused for each timer in turn
    for (int t = 0; t < 2; t++) begin
      if (enable[t] && !(t == 1 && mode[1] == 2'(dmtc_pkg::DMTC_M_SPLIT))) begin
        case (mode[t])
          2'(dmtc_pkg::DMTC_M_PRESC): begin
            // prescaler keeps its count across stops and byte writes
            next_presc[t] = 5'(presc[t] + 5'h01);
            if (presc[t] == dmtc_pkg::PRESC_LAST) begin
              sumHigh          = {1'b0, highByte[t]} + 9'h001;
              next_highByte[t] = sumHigh[7:0];
              ovf[t]           = sumHigh[8];
            end
          end
          2'(dmtc_pkg::DMTC_M_WIDE): begin
            sumLow          = {1'b0, lowByte[t]} + 9'h001;
            next_lowByte[t] = sumLow[7:0];
            if (sumLow[8]) begin
              sumHigh          = {1'b0, highByte[t]} + 9'h001;
              next_highByte[t] = sumHigh[7:0];
              ovf[t]           = sumHigh[8];
            end
          end
          2'(dmtc_pkg::DMTC_M_RELOAD): begin
            sumLow          = {1'b0, lowByte[t]} + 9'h001;
            next_lowByte[t] = sumLow[8] ? highByte[t] : sumLow[7:0];
            ovf[t]          = sumLow[8];
          end
          default: begin
            // split: low byte of timer 0 on timer 0 controls
            sumLow          = {1'b0, lowByte[t]} + 9'h001;
            next_lowByte[t] = sumLow[7:0];
            ovf[t]          = sumLow[8];
          end
        endcase
      end
    end

    // split high byte counts machine cycles on timer 1 run bit, ungated
    if (splitZero && runBit[1] && mcTick) begin
      sumHigh          = {1'b0, highByte[0]} + 9'h001;
      next_highByte[0] = sumHigh[7:0];
      ovfHighZero      = sumHigh[8];
    end

    // the baud pulse ignores the split silencing of the timer 1 flag
    next_baud = ovf[1];

    // register writes; hardware flag set below wins over software clear
    if (wrReq) begin
      if (hit(wb_adr_i, {1'b0, dmtc_pkg::ADDR_MODE})) begin
        next_timerModeRegister = wb_dat_i[7:0];
      end
      if (hit(wb_adr_i, {1'b0, dmtc_pkg::ADDR_CTRL})) begin
        next_timerControlRegister = wb_dat_i[7:0];
      end
      if (hit(wb_adr_i, {1'b0, dmtc_pkg::ADDR_LOW0}))  next_lowByte[0]  = wb_dat_i[7:0];
      if (hit(wb_adr_i, {1'b0, dmtc_pkg::ADDR_HIGH0})) next_highByte[0] = wb_dat_i[7:0];
      if (hit(wb_adr_i, dmtc_pkg::ADDR_LOW1))          next_lowByte[1]  = wb_dat_i[7:0];
      if (hit(wb_adr_i, dmtc_pkg::ADDR_HIGH1))         next_highByte[1] = wb_dat_i[7:0];
      if (hit(wb_adr_i, dmtc_pkg::ADDR_MASK))          next_mask        = wb_dat_i[1:0];
    end
    // status clears on read
    // an overflow in the same cycle sets it again below, so no event is lost
    if (rdReq && hit(wb_adr_i, dmtc_pkg::ADDR_STATUS)) begin
      next_status = 2'b00;
    end

    // overflow flags; timer 1 silenced while timer 0 split
    if (ovf[0]) begin
      next_timerControlRegister[dmtc_pkg::CTRL_OVF0] = 1'b1;
      next_status[0]                                  = 1'b1;
    end
    if ((ovf[1] && !splitZero) || ovfHighZero) begin
      next_timerControlRegister[dmtc_pkg::CTRL_OVF1] = 1'b1;
      next_status[1]                                  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, ack lasts one cycle
  // unmapped addresses still ack and read zero, so software never hangs
  always_comb begin
    next_ack    = req;
    next_rdData = 32'h0000_0000;
    if (rdReq) begin
      case (wb_adr_i)
        {1'b0, dmtc_pkg::ADDR_MODE}:  next_rdData = {24'h000000, timerModeRegister};
        {1'b0, dmtc_pkg::ADDR_CTRL}:  next_rdData = {24'h000000, timerControlRegister};
        {1'b0, dmtc_pkg::ADDR_LOW0}:  next_rdData = {24'h000000, lowByte[0]};
        {1'b0, dmtc_pkg::ADDR_HIGH0}: next_rdData = {24'h000000, highByte[0]};
        dmtc_pkg::ADDR_LOW1:          next_rdData = {24'h000000, lowByte[1]};
        dmtc_pkg::ADDR_HIGH1:         next_rdData = {24'h000000, highByte[1]};
        dmtc_pkg::ADDR_STATUS:        next_rdData = {30'h00000000, status};
        dmtc_pkg::ADDR_MASK:          next_rdData = {30'h00000000, mask};
        default:                      next_rdData = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  // every register resets to zero and the machine-cycle phase restarts with them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timerModeRegister    <= dmtc_pkg::RST_BYTE;
      timerControlRegister <= dmtc_pkg::RST_BYTE;
      lowByte              <= '{dmtc_pkg::RST_BYTE, dmtc_pkg::RST_BYTE};
      highByte             <= '{dmtc_pkg::RST_BYTE, dmtc_pkg::RST_BYTE};
      presc                <= '{dmtc_pkg::RST_PRESC, dmtc_pkg::RST_PRESC};
      status               <= dmtc_pkg::RST_EVT;
      mask                 <= dmtc_pkg::RST_EVT;
      ack                  <= 1'b0;
      baud                 <= 1'b0;
      rdData               <= 32'h0000_0000;
      irq                  <= 1'b0;
    end else begin
      timerModeRegister    <= next_timerModeRegister;
      timerControlRegister <= next_timerControlRegister;
      lowByte              <= next_lowByte;
      highByte             <= next_highByte;
      presc                <= next_presc;
      status               <= next_status;
      mask                 <= next_mask;
      ack                  <= next_ack;
      baud                 <= next_baud;
      rdData               <= next_rdData;
      irq                  <= |(next_status & next_mask);
    end
  end

  // outputs come straight from registers
  assign wb_ack_o  = ack;
  assign wb_dat_o  = rdData;
  assign baudPulse = baud;
endmodule
`default_nettype wire

// ===== tb/dmtc_checker.sv
// checker: bus handshake, read data, baud pulse and interrupt properties
`timescale 1ns/1ps
`default_nettype none
module dmtc_checker (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        baudPulse,
  input  wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // a fresh request, and a read being answered
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sRead;
    wb_ack_o && !wb_we_i;
  endsequence
  ack_late_a: assert property (sReq |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  rd_upper_a: assert property (sRead |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rd_mask_a: assert property (sRead ##0 wb_adr_i == dmtc_pkg::ADDR_MASK
    |-> wb_dat_o[7:2] == 6'h00) else $error("mask reads spare bits");
  stat_bits_a: assert property (sRead ##0 wb_adr_i == dmtc_pkg::ADDR_STATUS
    |-> wb_dat_o[7:2] == 6'h00) else $error("status reads spare bits");
  // overflows come at most once per machine cycle
  baud_gap_a: assert property (baudPulse |=> !baudPulse [*8])
    else $error("baud pulses too close");
  // only a bus access can take the interrupt away
  irq_drop_a: assert property ($fell(irq) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("irq fell without a bus access");
endmodule
bind dmtc_timer_top dmtc_checker u_dmtc_checker (
  .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .baudPulse(baudPulse), .irq(irq)
);
`default_nettype wire

// ===== tb/dmtc_pin_model.sv
// pin model: count pins and gate pins seen by the timers
`timescale 1ns/1ps
`default_nettype none
module dmtc_pin_model (
  input  wire logic mclk,
  output logic      cnt0 = 1'b1,
  output logic      cnt1 = 1'b1,
  output logic      gate0 = 1'b0,
  output logic      gate1 = 1'b0
);
  // n falling edges; each level held two machine cycles so none is missed
  task automatic pulses(input int t, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (t == 0) cnt0 <= 1'b0; else cnt1 <= 1'b0;
      repeat (24) @(posedge mclk);
      if (t == 0) cnt0 <= 1'b1; else cnt1 <= 1'b1;
      repeat (23) @(posedge mclk);
    end
  endtask
  // gate high for exactly c clocks
  task automatic gateFor(input int t, input int c);
    @(posedge mclk);
    if (t == 0) gate0 <= 1'b1; else gate1 <= 1'b1;
    repeat (c) @(posedge mclk);
    gate0 <= 1'b0;
    gate1 <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: table of timer runs, then counter, gate, irq and reset tests
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] mode; logic [7:0] ctrl; logic [31:0] init; logic [7:0] k;
    logic [31:0] expv; logic [3:0] chk; logic [1:0] st; logic [1:0] baud;
  } dmtc_row_t;
  localparam logic [4:0] aMode = {1'b0, dmtc_pkg::ADDR_MODE};
  localparam logic [4:0] aCtrl = {1'b0, dmtc_pkg::ADDR_CTRL};
  logic        mclk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, cnt0, cnt1, gate0, gate1, baud, irq;
  int          errCount = 0, compares = 0, baudCnt = 0, b0;
  logic [4:0]  cAdr [4] = '{{1'b0, dmtc_pkg::ADDR_LOW0}, {1'b0, dmtc_pkg::ADDR_HIGH0},
                            dmtc_pkg::ADDR_LOW1, dmtc_pkg::ADDR_HIGH1};
  // bytes: hi1 lo1 hi0 lo0; chk picks bytes to compare
  dmtc_row_t   rows [5] = '{
    '{8'h00, 8'h10, 32'h0000FF00, 8'd40, 32'h00000000, 4'hE, 2'h1, 2'h0},
    '{8'h11, 8'h50, 32'h12FDFFFE, 8'd3, 32'h13000001, 4'hF, 2'h1, 2'h0},
    '{8'h21, 8'h40, 32'hF0FE2211, 8'd5, 32'hF0F32211, 4'hF, 2'h2, 2'h1},
    '{8'h13, 8'h50, 32'hFFFF00FE, 8'd2, 32'h00010200, 4'hF, 2'h1, 2'h1},
    '{8'h33, 8'h40, 32'hFFFFFE00, 8'd3, 32'hFFFF0100, 4'hF, 2'h2, 2'h0}};
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (baud !== 1'b0) baudCnt <= baudCnt + 1;  // unknown counts too
  dmtc_timer_top u_dmtc_timer_top (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .countInputZero(cnt0), .countInputOne(cnt1),
    .gateInputZero(gate0), .gateInputOne(gate1), .baudPulse(baud), .irq(irq));
  dmtc_pin_model u_dmtc_pin_model (
    .mclk(mclk), .cnt0(cnt0), .cnt1(cnt1), .gate0(gate0), .gate1(gate1));
  ////////////////////////////////////////////////////////////////
  // one classic cycle; read data lands in q at the ack edge
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) errCount++;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic endSim();
    $display("compares %0d errors %0d", compares, errCount);
    if (errCount == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    errCount++;
    endSim();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    // run window is whole machine cycles: three clocks of bus overhead taken off
    foreach (rows[r]) begin
      xfer(1'b1, aMode, rows[r].mode);
      for (int i = 0; i < 4; i++) xfer(1'b1, cAdr[i], rows[r].init[8*i +: 8]);
      b0 = baudCnt;
      xfer(1'b1, aCtrl, rows[r].ctrl);
      repeat (dmtc_pkg::OSC_PER_MC * int'(rows[r].k) - 3) @(posedge mclk);
      xfer(1'b1, aCtrl, 8'h00);
      for (int i = 0; i < 4; i++) if (rows[r].chk[i]) begin
        xfer(1'b0, cAdr[i], 8'h00);
        check("count", q, {24'h0, rows[r].expv[8*i +: 8]});
      end
      xfer(1'b0, dmtc_pkg::ADDR_STATUS, 8'h00);
      check("status", q, {30'h0, rows[r].st});
      check("baud", 32'(baudCnt - b0), {30'h0, rows[r].baud});
    end
    // external falling edges, each timer in turn
    for (int t = 0; t < 2; t++) begin
      xfer(1'b1, aMode, t ? 8'h50 : 8'h05);
      xfer(1'b1, cAdr[2*t], 8'h00);
      xfer(1'b1, aCtrl, t ? 8'h40 : 8'h10);
      u_dmtc_pin_model.pulses(t, 3);
      repeat (36) @(posedge mclk);
      xfer(1'b1, aCtrl, 8'h00);
      xfer(1'b0, cAdr[2*t], 8'h00);
      check("edges", q, 32'h3);
    end
    // gated timer counts only the four gate-high machine cycles
    for (int t = 0; t < 2; t++) begin
      xfer(1'b1, aMode, t ? 8'h90 : 8'h09);
      xfer(1'b1, cAdr[2*t], 8'h00);
      xfer(1'b1, aCtrl, t ? 8'h40 : 8'h10);
      repeat (36) @(posedge mclk);
      u_dmtc_pin_model.gateFor(t, 48);
      repeat (24) @(posedge mclk);
      xfer(1'b1, aCtrl, 8'h00);
      sel <= 4'h0;
      xfer(1'b1, cAdr[2*t], 8'hAA);
      sel <= 4'hF;
      xfer(1'b0, cAdr[2*t], 8'h00);
      check("gated", q, 32'h4);
    end
    // masked overflow, then unmask, flag clear, status read clear
    xfer(1'b1, aMode, 8'h01);
    xfer(1'b1, cAdr[0], 8'hFE);
    xfer(1'b1, cAdr[1], 8'hFF);
    xfer(1'b1, aCtrl, 8'h10);
    repeat (36) @(posedge mclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b0, aCtrl, 8'h00);
    check("flag", q, 32'h30);
    xfer(1'b1, dmtc_pkg::ADDR_MASK, 8'h01);
    repeat (2) @(posedge mclk);
    check("irq on", {31'h0, irq}, 32'h1);
    xfer(1'b1, aCtrl, 8'h10);
    xfer(1'b0, aCtrl, 8'h00);
    check("flag clr", q, 32'h10);
    xfer(1'b0, dmtc_pkg::ADDR_STATUS, 8'h00);
    repeat (2) @(posedge mclk);
    check("irq off", {31'h0, irq}, 32'h0);
    // second reset in mid-run clears every register
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 32; a += 4) begin
      xfer(1'b0, 5'(a), 8'h00);
      check("reset", q, 32'h0);
    end
    endSim();
  end
endmodule
`default_nettype wire
